// [verilog/sscc_pkg.sv]
// sscc_pkg: constants and types for the synchronous sram cycle control
// assumes a single rising-edge clock and synchronous controller inputs
//
// Function
// - cycle type taken from select on load
// - cycle type held until next load
// - low select writes; all enables low, full width
// - strap low selects linear burst order
// - strap high or open selects interleaved order
// - four byte lanes, write data on rising edge
// - wide configuration adds one bit per lane
// - advance steps counter, ignores select; low loads
// - write only enabled bytes, enables with address
// - clock gate high holds all internal state
// - chip selects sampled only on load cycles
package sscc_pkg;

  localparam int unsigned ADDR_W    = 17;
  localparam int unsigned LANES     = 4;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned LANE_W    = 9;
  localparam int unsigned BURST_W   = 2;
  localparam int unsigned DATA_W    = LANES * LANE_W;
  localparam int unsigned PARITY_POS = 8;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [DATA_W-1:0]  DATA_RESET = '0;

  typedef enum logic [1:0]
  {
    SSCC_IDLE  = 2'b00,
    SSCC_READ  = 2'b01,
    SSCC_WRITE = 2'b10
  } sscc_state_t;

  // one access as it moves down the pipeline
  typedef struct packed
  {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  write_n;
  } sscc_cyc_t;

  localparam sscc_cyc_t CYC_RESET = '0;

endpackage : sscc_pkg

// [verilog/sscc_mem.sv]
// sscc_mem: byte-lane array, one registered read port, one lane-masked write port
// assumes the caller gates both ports with the clock enable
`timescale 1ns/10ps
`default_nettype none
module sscc_mem
  import sscc_pkg::*;
#(
  parameter int unsigned LN    = 4,
  parameter int unsigned LW    = 9,
  parameter int unsigned AW    = 17
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // read port
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [LN*LW-1:0] rd_data_q,
  // write port
  input  wire logic [LN-1:0]    wr_lane,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [LN*LW-1:0] wr_data
);

  logic [LN*LW-1:0] rd_data_d;

  genvar g;
  generate
    for (g = 0; g < LN; g++)
    begin : g_lane
      logic [LW-1:0] arr [0:(1<<AW)-1];
      always_ff @(posedge clk)
      begin
        if (wr_lane[g])
        begin
          arr[wr_addr] <= wr_data[g*LW +: LW];
        end
      end
      always_comb
      begin
        rd_data_d[g*LW +: LW] = rd_en ? arr[rd_addr] : rd_data_q[g*LW +: LW];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

endmodule : sscc_mem
`default_nettype wire

// [verilog/sscc_top.sv]
// sscc_top: cycle control, burst counter and byte-lane data path
// assumes controller drives all inputs synchronous to CORE_CLK
`timescale 1ns/10ps
`default_nettype none
module sscc_top
  import sscc_pkg::*;
#(
  parameter bit PARITY_EN = 1'b1
)
(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  // address and cycle control
  input  wire logic [ADDR_W-1:0] SYNC_ADDRESS,
  input  wire logic              ADVANCE_OR_LOAD_N,
  input  wire logic              READ_WRITE_N,
  input  wire logic              CHIP_SELECT_N,
  input  wire logic              CHIP_SELECT_SECOND_N,
  input  wire logic              CHIP_SELECT_THIRD_HIGH,
  input  wire logic              CLOCK_GATE_N,
  input  wire logic              SNOOZE_REQUEST,
  input  wire logic              OUTPUT_ENABLE_N,
  input  wire logic              BURST_ORDER_STRAP,
  // byte lanes, a in lane 0 up to d in lane 3
  input  wire logic [LANES-1:0]  LANE_WRITE_N,
  input  wire logic [DATA_W-1:0] LANE_DATA_IN,
  output var  logic [DATA_W-1:0] LANE_DATA_OUT,
  output var  logic [DATA_W-1:0] LANE_DATA_OE
);

  function automatic logic [DATA_W-1:0] lane_mask();
    logic [DATA_W-1:0] m;
    m = '1;
    for (int i = 0; i < LANES; i++)
    begin
      m[i*LANE_W + PARITY_POS] = PARITY_EN;
    end
    return m;
  endfunction : lane_mask

  localparam logic [DATA_W-1:0] DATA_MASK = lane_mask();

  sscc_state_t          st_q, st_d;
  logic [ADDR_W-1:0]    base_q, base_d;
  logic [BURST_W-1:0]   start_q, start_d;
  logic [BURST_W-1:0]   cnt_q, cnt_d;
  logic [BURST_W-1:0]   seq;
  logic [BURST_W-1:0]   cnt_nx;
  sscc_cyc_t            s1_q, s1_d, s2_q, s2_d;
  logic [DATA_W-1:0]    dout_q, dout_d;
  logic [DATA_W-1:0]    doe_q, doe_d;
  logic                 run;
  logic                 load;
  logic                 sel;
  logic                 rd_en;
  logic [LANES-1:0]     wr_lane;
  logic [DATA_W-1:0]    rd_data;

  assign run  = !CLOCK_GATE_N && !SNOOZE_REQUEST;
  assign load = !ADVANCE_OR_LOAD_N;
  assign sel  = !CHIP_SELECT_N && !CHIP_SELECT_SECOND_N && CHIP_SELECT_THIRD_HIGH;

  // cycle control and burst counter
  always_comb
  begin
    st_d    = st_q;
    base_d  = base_q;
    start_d = start_q;
    cnt_d   = cnt_q;
    cnt_nx  = BURST_W'(cnt_q + BURST_STEP);
    seq     = BURST_ORDER_STRAP ? (start_q ^ cnt_nx)
                                : BURST_W'(start_q + cnt_nx);
    s1_d    = s1_q;
    s2_d    = s2_q;
    if (run)
    begin
      if (load)
      begin
        st_d    = sel ? (READ_WRITE_N ? SSCC_READ : SSCC_WRITE) : SSCC_IDLE;
        base_d  = SYNC_ADDRESS;
        start_d = SYNC_ADDRESS[BURST_W-1:0];
        cnt_d   = BURST_ZERO;
        s1_d.addr = SYNC_ADDRESS;
      end
      else
      begin
        // select ignored, type kept
        cnt_d     = (st_q != SSCC_IDLE) ? cnt_nx : cnt_q;
        s1_d.addr = {base_q[ADDR_W-1:BURST_W], seq};
      end
      s1_d.valid   = (st_d != SSCC_IDLE);
      s1_d.write   = (st_d == SSCC_WRITE);
      s1_d.write_n = LANE_WRITE_N;
      s2_d         = s1_q;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      st_q    <= SSCC_IDLE;
      base_q  <= '0;
      start_q <= BURST_ZERO;
      cnt_q   <= BURST_ZERO;
      s1_q    <= CYC_RESET;
      s2_q    <= CYC_RESET;
    end
    else
    begin
      st_q    <= st_d;
      base_q  <= base_d;
      start_q <= start_d;
      cnt_q   <= cnt_d;
      s1_q    <= s1_d;
      s2_q    <= s2_d;
    end
  end

  // array access: read one stage ahead, write late with its data
  assign rd_en = run && s1_q.valid && !s1_q.write;
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      wr_lane[i] = run && s2_q.valid && s2_q.write && !s2_q.write_n[i];
    end
  end

  sscc_mem #(
    .LN (LANES),
    .LW (LANE_W),
    .AW (ADDR_W)
  ) i_sscc_mem (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .rd_en     (rd_en),
    .rd_addr   (s1_q.addr),
    .rd_data_q (rd_data),
    .wr_lane   (wr_lane),
    .wr_addr   (s2_q.addr),
    .wr_data   (LANE_DATA_IN & DATA_MASK)
  );

  // registered output lanes
  always_comb
  begin
    dout_d = dout_q;
    doe_d  = doe_q;
    if (run)
    begin
      dout_d = rd_data & DATA_MASK;
      doe_d  = (s2_q.valid && !s2_q.write && !OUTPUT_ENABLE_N) ? DATA_MASK : '0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      dout_q <= DATA_RESET;
      doe_q  <= DATA_RESET;
    end
    else
    begin
      dout_q <= dout_d;
      doe_q  <= doe_d;
    end
  end

  assign LANE_DATA_OUT = dout_q;
  assign LANE_DATA_OE  = doe_q;

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  a_type_on_load: assert property (
    run && load && sel |=> st_q == (($past(READ_WRITE_N)) ? SSCC_READ : SSCC_WRITE))
    else $error("cycle type not taken from select at load");

  a_type_held: assert property (
    run && !load && st_q != SSCC_IDLE |=> $stable(st_q) && $stable(base_q))
    else $error("cycle type changed during burst");

  a_full_write: assert property (
    run && s2_q.valid && s2_q.write && s2_q.write_n == '0 |-> wr_lane == '1)
    else $error("full width write missed a lane");

  a_linear_order: assert property (
    run && !load && st_q != SSCC_IDLE && !BURST_ORDER_STRAP
    |=> s1_q.addr[1:0] == BURST_W'($past(start_q) + $past(cnt_q) + BURST_STEP))
    else $error("linear burst address wrong");

  a_ilv_order: assert property (
    run && !load && st_q != SSCC_IDLE && BURST_ORDER_STRAP
    |=> s1_q.addr[1:0] == ($past(start_q) ^ BURST_W'($past(cnt_q) + BURST_STEP)))
    else $error("interleaved burst address wrong");

  a_write_lanes: assert property (
    run && s2_q.valid && s2_q.write |-> wr_lane == ~s2_q.write_n)
    else $error("byte enables not applied to write");

  a_gate_hold: assert property (
    !run |=> $stable(st_q) && $stable(s1_q) && $stable(s2_q) && $stable(dout_q)
             && $stable(doe_q) && $stable(cnt_q))
    else $error("state moved while clock gated");

  a_deselect: assert property (
    run && load && !sel |=> st_q == SSCC_IDLE ##1 (!s2_q.valid || !$past(run)))
    else $error("deselect on load not honoured");

  a_parity_off: assert property (
    PARITY_EN || ((LANE_DATA_OE & ~DATA_MASK) == '0))
    else $error("parity bit driven in narrow configuration");

  a_read_latency: assert property (
    run && load && sel && READ_WRITE_N && !OUTPUT_ENABLE_N ##1 run ##1 (run && !OUTPUT_ENABLE_N)
    |=> LANE_DATA_OE == DATA_MASK)
    else $error("read data not driven two cycles after load");

endmodule : sscc_top
`default_nettype wire

// [sim/sscc_ctl_model.sv]
// sscc_ctl_model: controller end of the shared lane bus
// assumes device and controller never drive together
`timescale 1ns/10ps
`default_nettype none
module sscc_ctl_model
  import sscc_pkg::*;
(
  // device side
  input  wire logic [DATA_W-1:0] dev_out,
  input  wire logic [DATA_W-1:0] dev_oe,
  // controller side
  input  wire logic [DATA_W-1:0] ctl_data,
  input  wire logic              ctl_oe,
  output var  logic [DATA_W-1:0] bus
);
  // undriven bits show a changing pattern
  always_comb
  begin
    for (int i = 0; i < DATA_W; i++)
      bus[i] = dev_oe[i] ? dev_out[i] : (ctl_oe ? ctl_data[i] : ~ctl_data[i]);
  end
endmodule : sscc_ctl_model
`default_nettype wire

// [sim/testbench.sv]
// testbench: load and advance cycles against sscc_top, lane data checked
// assumes one clock; inputs driven at the rising edge
`timescale 1ns/10ps
`default_nettype none
module testbench
  import sscc_pkg::*;
();
  typedef struct packed {logic v; logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} sscc_ent_t;
  logic              CORE_CLK = 1'b0;
  logic              RESET, ADVANCE_OR_LOAD_N, READ_WRITE_N, CLOCK_GATE_N, SNOOZE_REQUEST;
  logic              BURST_ORDER_STRAP, wdo, bw, bact, pen;
  logic [2:0]        cs;
  logic [1:0]        bn;
  logic [LANES-1:0]  LANE_WRITE_N;
  logic [ADDR_W-1:0] SYNC_ADDRESS, ba;
  logic [DATA_W-1:0] LANE_DATA_IN, LANE_DATA_OUT, LANE_DATA_OE, wd, nout, noe;
  localparam logic [DATA_W-1:0] NARROW = {LANES{1'b0, {BYTE_W{1'b1}}}};
  logic [DATA_W-1:0] mem [0:255];
  logic [2:0]        dsel [3] = '{3'b101, 3'b011, 3'b000};
  sscc_ent_t         q0, q1, q2, nx;
  int                mismatches, n_tests;

  always #50 CORE_CLK = ~CORE_CLK;

  sscc_top #(.PARITY_EN(1'b1)) i_sscc_top (.CORE_CLK, .RESET, .SYNC_ADDRESS,
    .ADVANCE_OR_LOAD_N, .READ_WRITE_N, .CHIP_SELECT_N(cs[2]), .CHIP_SELECT_SECOND_N(cs[1]),
    .CHIP_SELECT_THIRD_HIGH(cs[0]), .CLOCK_GATE_N, .SNOOZE_REQUEST, .OUTPUT_ENABLE_N(1'b0),
    .BURST_ORDER_STRAP, .LANE_WRITE_N, .LANE_DATA_IN, .LANE_DATA_OUT, .LANE_DATA_OE);
  // narrow configuration on the same controller traffic
  sscc_top #(.PARITY_EN(1'b0)) i_sscc_top_narrow (.CORE_CLK, .RESET, .SYNC_ADDRESS,
    .ADVANCE_OR_LOAD_N, .READ_WRITE_N, .CHIP_SELECT_N(cs[2]), .CHIP_SELECT_SECOND_N(cs[1]),
    .CHIP_SELECT_THIRD_HIGH(cs[0]), .CLOCK_GATE_N, .SNOOZE_REQUEST, .OUTPUT_ENABLE_N(1'b0),
    .BURST_ORDER_STRAP, .LANE_WRITE_N, .LANE_DATA_IN, .LANE_DATA_OUT(nout),
    .LANE_DATA_OE(noe));
  sscc_ctl_model i_sscc_ctl_model (.dev_out(LANE_DATA_OUT), .dev_oe(LANE_DATA_OE),
    .ctl_data(wd), .ctl_oe(wdo), .bus(LANE_DATA_IN));

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    n_tests++;
    if (e !== g)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one clock of controller traffic; fz[0] gates the clock, fz[1] snoozes
  task automatic op(input logic ld, rw, input logic [1:0] fz, input logic [2:0] c,
                    input logic [ADDR_W-1:0] a, input logic [LANES-1:0] wn,
                    input logic [DATA_W-1:0] d);
    @(posedge CORE_CLK);
    if (pen)
    begin
      q2 = q1;
      q1 = q0;
      q0 = nx;
    end
    wd                <= q1.d;
    wdo               <= q1.v & q1.w;
    pen               = (fz == 2'h0);
    CLOCK_GATE_N      <= fz[0];
    SNOOZE_REQUEST    <= fz[1];
    ADVANCE_OR_LOAD_N <= !ld;
    READ_WRITE_N      <= rw;
    cs                <= c;
    SYNC_ADDRESS      <= a;
    LANE_WRITE_N      <= wn;
    if (pen)
    begin
      if (ld)
      begin
        bact = (c == 3'b001);
        bw = !rw;
        ba = a;
        bn = 2'h0;
      end
      else
        bn = bn + 2'h1;
      nx.a = {ba[ADDR_W-1:2], BURST_ORDER_STRAP ? ba[1:0] ^ bn : ba[1:0] + bn};
      nx.v = bact;
      nx.w = bw;
      for (int i = 0; i < LANES; i++)
        if (bact && bw && !wn[i])
          mem[nx.a[7:0]][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      nx.d = bw ? d : mem[nx.a[7:0]];
    end
    @(negedge CORE_CLK);
    chk("lane_oe", {DATA_W{q2.v & !q2.w}}, LANE_DATA_OE);
    chk("lane_oe_narrow", {DATA_W{q2.v & !q2.w}} & NARROW, noe);
    if (q2.v && !q2.w)
    begin
      chk("lane_out", q2.d, LANE_DATA_OUT);
      chk("lane_out_narrow", q2.d & NARROW, nout);
    end
  endtask : op

  task automatic rd(input logic [ADDR_W-1:0] a);
    op(1'b1, 1'b1, 2'h0, 3'b001, a, 4'hf, '0);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) op(1'b1, 1'b1, 2'h0, 3'b000, '0, 4'hf, '0);
  endtask : idle

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  initial
  begin
    {RESET, CLOCK_GATE_N, SNOOZE_REQUEST, BURST_ORDER_STRAP, ADVANCE_OR_LOAD_N} = 5'b10001;
    {READ_WRITE_N, cs, LANE_WRITE_N, SYNC_ADDRESS, wd, wdo} = '0;
    {q0, q1, q2, nx, bn, ba, bw, bact, pen} = '0;
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
    idle(2);
    op(1'b1, 1'b0, 2'h0, 3'b001, 'h10, 4'h0, 36'hfedcba987);
    op(1'b1, 1'b0, 2'h0, 3'b001, 'h11, 4'h0, 36'h123456789);
    op(1'b1, 1'b0, 2'h0, 3'b001, 'h11, 4'h5, 36'h5a5a5a5a5);
    idle(1);
    rd('h10);
    rd('h11);
    idle(3);
    $display("test lanes done");
    for (int i = 0; i < 4; i++)
      op(i == 0, i != 0, 2'h0, 3'b001, 'h22, 4'h0, {4{9'h100 + 9'(i)}});
    idle(1);
    for (int i = 0; i < 4; i++)
      rd(ADDR_W'('h20 + i));
    idle(3);
    $display("test linear done");
    @(posedge CORE_CLK);
    BURST_ORDER_STRAP <= 1'b1;
    idle(2);
    for (int i = 0; i < 4; i++)
      op(1'b1, 1'b0, 2'h0, 3'b001, ADDR_W'('h30 + i), 4'h0, {4{9'h0a0 + 9'(i)}});
    idle(1);
    for (int i = 0; i < 4; i++)
      op(i == 0, i == 0, 2'h0, 3'b001, 'h31, 4'h0, '0);
    idle(3);
    $display("test interleaved done");
    rd('h10);
    op(1'b1, 1'b0, 2'h1, 3'b001, 'h10, 4'h0, '0);
    rd('h11);
    op(1'b1, 1'b0, 2'h2, 3'b001, 'h10, 4'h0, '0);
    idle(2);
    rd('h10);
    idle(3);
    $display("test freeze done");
    foreach (dsel[k])
      op(1'b1, k[0], 2'h0, dsel[k], 'h10, 4'h0, '0);
    idle(1);
    rd('h10);
    idle(3);
    $display("test deselect done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
